// ===== ssi_position_pkg.sv
// Package of constants and carrier types for the serial position output.
package ssi_position_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLOCK_HZ = 10_000_000;
    localparam int unsigned MONOFLOP_HOLD_INTERVAL_NS = 25_000;
    localparam int unsigned BIT_CHANGE_DELAY_NS = 90;
    localparam int unsigned SAMPLE_RATE_DEFAULT_HZ = 35_000;
    localparam int unsigned SAMPLE_RATE_FAST_HZ = 375_000;
    localparam int unsigned CLOCK_PERIOD_NS = 1_000_000_000 / CLOCK_HZ;
    localparam int unsigned MONOFLOP_CYCLES = (MONOFLOP_HOLD_INTERVAL_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int unsigned BIT_CHANGE_CYCLES_RAW = BIT_CHANGE_DELAY_NS / CLOCK_PERIOD_NS;
    localparam int unsigned BIT_CHANGE_CYCLES = (BIT_CHANGE_CYCLES_RAW < 1) ? 1 : BIT_CHANGE_CYCLES_RAW;
    localparam int unsigned SAMPLE_DIV_DEFAULT = CLOCK_HZ / SAMPLE_RATE_DEFAULT_HZ;
    localparam int unsigned SAMPLE_DIV_FAST = CLOCK_HZ / SAMPLE_RATE_FAST_HZ;

    // ------------------------------------------------------------------
    // Word layout
    // ------------------------------------------------------------------
    localparam int unsigned POS_BITS_MIN = 12;
    localparam int unsigned POS_BITS_MAX = 21;
    localparam int unsigned POS_BITS_DEFAULT = 21;
    localparam logic ERROR_FLAG_OK = 1'b0;
    localparam logic ERROR_FLAG_FAULT = 1'b1;
    localparam logic DATA_IDLE_LEVEL = 1'b1;

    typedef struct packed {
        logic [POS_BITS_MAX-1:0] position;
        logic fault;
    } sample_word_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_MONOFLOP = 2'b10
    } link_state_t;

endpackage : ssi_position_pkg

// ===== ssi_sample_buffer.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
module ssi_sample_buffer (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire ssi_position_pkg::sample_word_t i_data,
    input wire logic i_valid,
    output logic o_ready,
    output ssi_position_pkg::sample_word_t o_data,
    output logic o_valid,
    input wire logic i_ready
);
    import ssi_position_pkg::*;

    sample_word_t mem_reg [2];
    logic wr_ptr_reg;
    logic rd_ptr_reg;
    logic [1:0] count_reg;
    logic push;
    logic pop;

    assign o_ready = (count_reg != 2'd2);
    assign o_valid = (count_reg != 2'd0);
    assign o_data = mem_reg[rd_ptr_reg];
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
        end else if (push) begin
            mem_reg[wr_ptr_reg] <= i_data;
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'd0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 2'd1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 2'd1;
            end
        end
    end

endmodule : ssi_sample_buffer

// ===== ssi_pin_sync.sv
// Two-flop synchroniser for a level from outside the clock domain.
`timescale 1ns/1ps
module ssi_pin_sync (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_async,
    output logic o_sync
);
    logic meta_reg;

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta_reg <= 1'b1;
            o_sync <= 1'b1;
        end else begin
            meta_reg <= i_async;
            o_sync <= meta_reg;
        end
    end

endmodule : ssi_pin_sync

// ===== ssi_position_output.sv
// Serial position output of the encoder, slave end of the synchronous serial link.
`timescale 1ns/1ps
module ssi_position_output #(
    parameter int unsigned POS_BITS = ssi_position_pkg::POS_BITS_DEFAULT,
    parameter bit HAS_SELF_TEST = 1'b1,
    parameter bit FAST_SAMPLE = 1'b0
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_link_clock,
    output logic o_link_data,
    input wire logic [ssi_position_pkg::POS_BITS_MAX-1:0] i_position,
    input wire logic i_signal_fault,
    output logic o_busy,
    output logic o_sample_ready
);
    import ssi_position_pkg::*;

    localparam int unsigned FRAME_BITS = POS_BITS + (HAS_SELF_TEST ? 1 : 0);
    localparam int unsigned SAMPLE_DIV = FAST_SAMPLE ? SAMPLE_DIV_FAST : SAMPLE_DIV_DEFAULT;

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (POS_BITS < POS_BITS_MIN || POS_BITS > POS_BITS_MAX) begin : g_bad_width
        $error("Position width must lie between 12 and 21 bits.");
    end
    if (BIT_CHANGE_CYCLES > 1) begin : g_bad_timing
        $error("Clock too fast for the bit change delay logic.");
    end

    // ------------------------------------------------------------------
    // Sample refresh and buffering
    // ------------------------------------------------------------------
    logic [15:0] sample_div_reg;
    logic sample_tick_reg;
    sample_word_t sample_in;
    sample_word_t sample_out;
    logic buf_in_ready;
    logic buf_out_valid;
    logic buf_take;
    sample_word_t held_reg;

    // The sampler runs free from reset, so position is served without setup.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sample_div_reg <= 16'h0000;
            sample_tick_reg <= 1'b0;
        end else if (sample_div_reg == 16'(SAMPLE_DIV - 1)) begin
            sample_div_reg <= 16'h0000;
            sample_tick_reg <= 1'b1;
        end else begin
            sample_div_reg <= sample_div_reg + 16'h0001;
            sample_tick_reg <= 1'b0;
        end
    end

    // Position passes unchanged, as plain binary, right-aligned.
    assign sample_in.position = i_position;
    assign sample_in.fault = i_signal_fault ? ERROR_FLAG_FAULT : ERROR_FLAG_OK;

    ssi_sample_buffer u_buffer (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_data(sample_in),
        .i_valid(sample_tick_reg),
        .o_ready(buf_in_ready),
        .o_data(sample_out),
        .o_valid(buf_out_valid),
        .i_ready(buf_take)
    );

    // The held word is the oldest refresh waiting in the buffer; drained whenever not shifting.
    link_state_t state_reg;
    assign buf_take = (state_reg != ST_SHIFT);

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            held_reg <= '0;
        end else if (buf_take && buf_out_valid) begin
            held_reg <= sample_out;
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_sample_ready <= 1'b0;
        end else begin
            o_sample_ready <= buf_in_ready;
        end
    end

    // ------------------------------------------------------------------
    // Link clock sampling
    // ------------------------------------------------------------------
    logic link_clock_sync;
    logic link_clock_prev_reg;
    logic link_fall;
    logic link_rise;

    ssi_pin_sync u_clock_sync (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_async(i_link_clock),
        .o_sync(link_clock_sync)
    );

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            link_clock_prev_reg <= 1'b1;
        end else begin
            link_clock_prev_reg <= link_clock_sync;
        end
    end

    // The master owns the clock; the block only follows its edges.
    assign link_fall = link_clock_prev_reg && !link_clock_sync;
    assign link_rise = !link_clock_prev_reg && link_clock_sync;

    // ------------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------------
    logic [POS_BITS_MAX:0] frame_reg;
    logic [4:0] bits_left_reg;
    logic [15:0] mono_cnt_reg;

    function automatic logic [POS_BITS_MAX:0] build_frame(input sample_word_t w);
        logic [POS_BITS_MAX:0] f;
        f = '0;
        // Word is left-aligned so the top bit shifts out first.
        f[POS_BITS_MAX -: POS_BITS_MAX] = w.position << (POS_BITS_MAX - POS_BITS);
        if (HAS_SELF_TEST) begin
            f[POS_BITS_MAX - POS_BITS] = w.fault;
        end
        return f;
    endfunction : build_frame

    // A falling edge in idle latches the word; each rising edge but the first and the last shifts one bit.
    // Edges within the monoflop time restart the hold rather than starting a frame.
    // A frame that the master cuts short ends after the same quiet time, so the block never hangs.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_reg <= ST_IDLE;
            frame_reg <= '0;
            bits_left_reg <= 5'd0;
            mono_cnt_reg <= 16'h0000;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (link_fall) begin
                        frame_reg <= build_frame(held_reg);
                        bits_left_reg <= 5'(FRAME_BITS);
                        mono_cnt_reg <= 16'(MONOFLOP_CYCLES);
                        state_reg <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (link_rise && bits_left_reg == 5'd0) begin
                        mono_cnt_reg <= 16'(MONOFLOP_CYCLES);
                        state_reg <= ST_MONOFLOP;
                    end else if (link_rise) begin
                        mono_cnt_reg <= 16'(MONOFLOP_CYCLES);
                        bits_left_reg <= bits_left_reg - 5'd1;
                        // The first rise only presents the top bit; later rises bring up the next one.
                        if (bits_left_reg != 5'(FRAME_BITS)) begin
                            frame_reg <= {frame_reg[POS_BITS_MAX-1:0], 1'b0};
                        end
                    end else if (link_fall) begin
                        mono_cnt_reg <= 16'(MONOFLOP_CYCLES);
                    end else if (mono_cnt_reg == 16'h0001) begin
                        state_reg <= ST_IDLE;
                    end else begin
                        mono_cnt_reg <= mono_cnt_reg - 16'h0001;
                    end
                end
                ST_MONOFLOP: begin
                    if (link_fall || link_rise) begin
                        mono_cnt_reg <= 16'(MONOFLOP_CYCLES);
                    end else if (mono_cnt_reg == 16'h0001) begin
                        state_reg <= ST_IDLE;
                    end else begin
                        mono_cnt_reg <= mono_cnt_reg - 16'h0001;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Data leaves the idle level once the first rise is seen, and each bit stands until the next rise.
    // The pin synchroniser costs a few system clocks, so at this system clock the update lags a link
    // edge by more than 90 ns; masters must sample late in the bit, as the usual falling-edge reading does.
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_link_data <= DATA_IDLE_LEVEL;
            o_busy <= 1'b0;
        end else begin
            o_busy <= (state_reg != ST_IDLE);
            if (state_reg == ST_SHIFT && bits_left_reg != 5'(FRAME_BITS)) begin
                o_link_data <= frame_reg[POS_BITS_MAX];
            end else begin
                o_link_data <= DATA_IDLE_LEVEL;
            end
        end
    end

endmodule : ssi_position_output

// ===== ssi_position_output_assertions.sv
// Concurrent checks on the ports of the serial position output.
`timescale 1ns/1ps
module ssi_position_output_checker #(
    parameter int unsigned POS_BITS = 21,
    parameter bit HAS_SELF_TEST = 1'b1,
    parameter bit FAST_SAMPLE = 1'b0
) (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_link_clock,
    input wire logic o_link_data,
    input wire logic [ssi_position_pkg::POS_BITS_MAX-1:0] i_position,
    input wire logic i_signal_fault,
    input wire logic o_busy,
    input wire logic o_sample_ready
);
    import ssi_position_pkg::*;
    localparam int unsigned FRAME_RISES = POS_BITS + HAS_SELF_TEST + 1;
    logic [2:0] sync_reg;
    logic [9:0] quiet_reg;
    logic [9:0] rise_age_reg;
    logic [9:0] fall_age_reg;
    logic [5:0] rise_cnt_reg;
    logic rise;
    logic fall;
    // The pin is sampled like the block does, so ages are within a cycle of its own view.
    assign rise = sync_reg[1] & ~sync_reg[2];
    assign fall = ~sync_reg[1] & sync_reg[2];
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync_reg <= 3'h7;
        end else begin
            sync_reg <= {sync_reg[1:0], i_link_clock};
        end
    end
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            quiet_reg <= 10'h000;
            rise_age_reg <= 10'h3FF;
            fall_age_reg <= 10'h3FF;
        end else begin
            quiet_reg <= (rise | fall) ? 10'h000 : quiet_reg + {9'h000, ~&quiet_reg};
            rise_age_reg <= rise ? 10'h000 : rise_age_reg + {9'h000, ~&rise_age_reg};
            fall_age_reg <= fall ? 10'h000 : fall_age_reg + {9'h000, ~&fall_age_reg};
        end
    end
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rise_cnt_reg <= 6'h00;
        end else if (fall && !o_busy) begin
            rise_cnt_reg <= 6'h00;
        end else if (rise) begin
            rise_cnt_reg <= rise_cnt_reg + 6'h01;
        end
    end
    a_reset_line_idle: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        $rose(i_reset_n) |-> o_link_data && !o_busy) else $error("not idle after reset");
    a_idle_line_high: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        !o_busy |-> o_link_data) else $error("data low while idle");
    a_request_starts_frame: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        fall && !o_busy |-> ##[1:6] o_busy) else $error("request not taken");
    a_busy_has_cause: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        $rose(o_busy) |-> fall_age_reg <= 10'h008) else $error("busy without request");
    a_monoflop_min_hold: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        $fell(o_busy) |-> quiet_reg >= 10'h0F5) else $error("hold too short");
    a_monoflop_max_hold: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        o_busy |-> quiet_reg <= 10'h104) else $error("hold too long");
    a_bit_after_rise: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        $changed(o_link_data) |-> rise_age_reg <= 10'h005) else $error("data moved off a rise");
    a_frame_bit_count: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        $fell(o_busy) |-> rise_cnt_reg == 6'(FRAME_RISES)) else $error("frame length wrong");
    a_buffer_ready_up: assert property (@(posedge i_clock) disable iff (!i_reset_n)
        $rose(i_reset_n) |-> ##[0:8] o_sample_ready) else $error("buffer never ready");
endmodule : ssi_position_output_checker
bind ssi_position_output ssi_position_output_checker #(.POS_BITS(POS_BITS), .HAS_SELF_TEST(HAS_SELF_TEST),
    .FAST_SAMPLE(FAST_SAMPLE)) u_checker (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_link_clock(i_link_clock),
    .o_link_data(o_link_data), .i_position(i_position), .i_signal_fault(i_signal_fault), .o_busy(o_busy),
    .o_sample_ready(o_sample_ready));

// ===== ssi_master_model.sv
// Behavioural interface master that clocks one position frame per call.
`timescale 1ns/1ps
module ssi_master_model #(
    parameter int HALF_NS = 400
) (
    output logic o_link_clock,
    input wire logic i_link_data
);
    initial o_link_clock = 1'b1;
    // Bits are taken just before the next rise, since the slave answers up to four system clocks (400 ns) after each edge.
    task automatic read_frame(input int nbits, output logic [31:0] word, output logic line_ok);
        word = 32'h0000_0000;
        line_ok = i_link_data;
        o_link_clock = 1'b0;
        #HALF_NS;
        for (int k = 0; k < nbits; k++) begin
            o_link_clock = 1'b1;
            #HALF_NS;
            o_link_clock = 1'b0;
            #(HALF_NS - 1);
            word = {word[30:0], i_link_data};
            #1;
        end
        o_link_clock = 1'b1;
        #(2 * HALF_NS);
        line_ok = line_ok & i_link_data;
        #26000;
    endtask : read_frame
endmodule : ssi_master_model

// ===== tb_top.sv
// Self-checking bench: two position outputs, each read by its own master model.
`timescale 1ns/1ps
module tb_top;
    import ssi_position_pkg::*;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [POS_BITS_MAX-1:0] position = 21'h1_A5C3;
    logic signal_fault = 1'b0;
    logic link_a;
    logic link_b;
    logic data_a;
    logic data_b;
    logic busy_a;
    logic busy_b;
    logic ready_a;
    logic ready_b;
    logic [31:0] word;
    logic line_ok;
    int mismatches = 0;
    int compares = 0;
    always #50 clock = ~clock;
    ssi_position_output #(.POS_BITS(21), .HAS_SELF_TEST(1'b1)) dut (.i_clock(clock),
        .i_reset_n(reset_n), .i_link_clock(link_a), .o_link_data(data_a), .i_position(position),
        .i_signal_fault(signal_fault), .o_busy(busy_a), .o_sample_ready(ready_a));
    ssi_position_output #(.POS_BITS(12), .HAS_SELF_TEST(1'b0), .FAST_SAMPLE(1'b1)) dut_short (.i_clock(clock),
        .i_reset_n(reset_n), .i_link_clock(link_b), .o_link_data(data_b), .i_position(position),
        .i_signal_fault(signal_fault), .o_busy(busy_b), .o_sample_ready(ready_b));
    ssi_master_model master_a (.o_link_clock(link_a), .i_link_data(data_a));
    ssi_master_model master_b (.o_link_clock(link_b), .i_link_data(data_b));
    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        compares++;
        if (seen !== expected) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask : check
    task automatic tally_and_finish();
        if (mismatches == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish
    // Waits just past two refresh periods so the new word has reached the held sample.
    task automatic set_inputs(input logic [20:0] pos, input logic fault);
        @(posedge clock);
        #1;
        position = pos;
        signal_fault = fault;
        repeat (600) @(posedge clock);
    endtask : set_inputs
    task automatic t_power_up();
        repeat (600) @(posedge clock);
        master_a.read_frame(22, word, line_ok);
        check(word, {10'h000, 21'h1_A5C3, 1'b0});
        check({31'h0000_0000, line_ok}, 32'h0000_0001);
        check({31'h0000_0000, busy_a}, 32'h0000_0000);
    endtask : t_power_up
    task automatic t_word_table();
        logic [20:0] table_pos [4];
        table_pos = '{21'h00_0000, 21'h1F_FFFF, 21'h15_5555, 21'h0A_AAAA};
        for (int i = 0; i < 4; i++) begin
            set_inputs(table_pos[i], i[0]);
            master_a.read_frame(22, word, line_ok);
            check(word, {10'h000, table_pos[i], i[0]});
            // At the fast rate the buffer fills while a frame shifts, so its ready drops.
            fork
                master_b.read_frame(12, word, line_ok);
                begin
                    #8001;
                    check({31'h0000_0000, ready_b}, 32'h0000_0000);
                end
            join
            check(word, {20'h0_0000, table_pos[i][11:0]});
            check({31'h0000_0000, line_ok}, 32'h0000_0001);
            check({31'h0000_0000, busy_b}, 32'h0000_0000);
        end
    endtask : t_word_table
    task automatic t_mid_frame_change();
        set_inputs(21'h0C_3A5F, 1'b0);
        fork
            master_a.read_frame(22, word, line_ok);
            begin
                #3001;
                position = 21'h13_C5A0;
                signal_fault = 1'b1;
            end
        join
        check(word, {10'h000, 21'h0C_3A5F, 1'b0});
        master_a.read_frame(22, word, line_ok);
        check(word, {10'h000, 21'h13_C5A0, 1'b1});
    endtask : t_mid_frame_change
    task automatic t_reset_again();
        @(posedge clock);
        #1;
        reset_n = 1'b0;
        repeat (10) @(posedge clock);
        check({30'h0000_0000, data_a, busy_a}, 32'h0000_0002);
        check({31'h0000_0000, ready_a}, 32'h0000_0000);
        #1;
        reset_n = 1'b1;
        set_inputs(21'h05_A5A5, 1'b0);
        master_a.read_frame(22, word, line_ok);
        check(word, {10'h000, 21'h05_A5A5, 1'b0});
        check({31'h0000_0000, ready_a}, 32'h0000_0001);
    endtask : t_reset_again
    initial begin
        repeat (10) @(posedge clock);
        #1;
        reset_n = 1'b1;
        t_power_up();
        t_word_table();
        t_mid_frame_change();
        t_reset_again();
        tally_and_finish();
    end
    initial begin
        #3_000_000;
        mismatches++;
        tally_and_finish();
    end
endmodule : tb_top
